// *** verilog/card_socket_pkg.sv ***
// constants shared by the smart card socket serial control block
package card_socket_pkg;
  // command word fields
  localparam int SUPPLY_LSB = 0;
  localparam int SELECT_BIT = 2;
  localparam int ROUTE_LSB = 3;
  localparam int CLKMODE_LSB = 5;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  // status word fields, low nibble reads zero
  localparam int STAT_ELEC_FAULT = 4;
  localparam int STAT_ATR_FAULT = 5;
  localparam int STAT_SUPPLY_READY = 6;
  localparam int STAT_PRESENT = 7;
  // supply levels
  localparam logic [1:0] SUPPLY_OFF = 2'h0;
  localparam logic [1:0] SUPPLY_1V8 = 2'h1;
  localparam logic [1:0] SUPPLY_3V = 2'h2;
  localparam logic [1:0] SUPPLY_5V = 2'h3;
  // data line routing
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_C4 = 2'h1;
  localparam logic [1:0] ROUTE_C8 = 2'h2;
  localparam logic [1:0] ROUTE_IO = 2'h3;
  // card clock modes
  localparam logic [2:0] CLK_SYNC = 3'h0;
  localparam logic [2:0] CLK_BIDIR = 3'h1;
  localparam logic [2:0] CLK_STOP_LOW = 3'h2;
  localparam logic [2:0] CLK_STOP_HIGH = 3'h3;
  localparam logic [2:0] CLK_DIV1 = 3'h4;
  localparam logic [2:0] CLK_DIV2 = 3'h5;
  localparam logic [2:0] CLK_DIV4 = 3'h6;
  localparam logic [2:0] CLK_DIV8 = 3'h7;
  // timing
  localparam int CLOCK_MHZ = 250;
  localparam int DEBOUNCE_MS = 32;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLOCK_MHZ * 1000;
  localparam int CLK_STOP_TIMEOUT_NS = 5000;
  localparam int CLK_STOP_CYCLES = (CLK_STOP_TIMEOUT_NS * CLOCK_MHZ + 999) / 1000;
  localparam int TIMER_W = 11;
endpackage : card_socket_pkg

// *** verilog/card_socket_serial_control.sv ***
// serial control port, command decoder and card pin control for one socket
//
// Notes on behaviour
// - sample serial input on serial clock rise
// - command word shifts in bit 7 first
// - status shifts out on each serial rise
// - load fall copies shift register to command
// - load low passes live status; rise freezes
// - chained devices pass output to next input
// - status: present, ready, atr, electrical, zeros
// - bits 1:0 pick card supply level
// - bits 7:5 pick card clock mode
// - selected card reset follows input, else holds
// - selected io joins data; deselected idles high
// - routed c4/c8 follow data line, else hold
// - sync mode clock follows input when selected
// - clock_input_a modes divide or stop the clock
// - bidirectional clock: either side pulls low
// - fault output low exactly with electrical fault
// - supply monitor low starts deactivation
// - no card traffic until supply ready, except the card clock in clock_input_a modes
// - electrical fault deactivates; atr fault reports only
// - bits 4:3 route data to c4, c8, io
// - deactivate: reset, clock, pins, then supply
// - presence debounced before present status asserts
`timescale 1ns/10ps
`default_nettype none
module card_socket_serial_control #(
  parameter int DEBOUNCE_CYCLES = card_socket_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic load_strobe,
  output logic serial_data_out,
  input wire logic reset_input,
  input wire logic sync_clock_in,
  output logic sync_clock_out,
  output logic sync_clock_oe,
  input wire logic clock_input_a,
  input wire logic data_line_in,
  output logic data_line_out,
  output logic data_line_oe,
  input wire logic supply_monitor_input,
  input wire logic presence_input,
  input wire logic electrical_fault_event,
  input wire logic atr_fault_event,
  input wire logic supply_ready_input,
  output logic fault_out,
  output logic fault_oe,
  output logic [1:0] supply_level,
  output logic card_reset,
  input wire logic card_clock_in,
  output logic card_clock_out,
  output logic card_clock_oe,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe,
  output logic card_c4,
  output logic card_c8
);
  localparam int NSYNC = 10;
  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);

  typedef enum logic [4:0] {
    DA_IDLE = 5'h01,
    DA_RESET = 5'h02,
    DA_CLOCK = 5'h04,
    DA_PINS = 5'h08,
    DA_SUPPLY = 5'h10
  } deact_state_t;

  // two-flop synchronisers for ten pin inputs; stage one feeds stage two only
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  logic sclk_prev_reg;
  logic load_prev_reg;
  logic clock_input_a_prev_reg;
  assign pins_raw = {serial_clock_in, serial_data_in, load_strobe, reset_input, sync_clock_in,
                     clock_input_a, data_line_in, supply_monitor_input, presence_input,
                     card_clock_in};
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 10'h3ff;
      sync_reg <= 10'h3ff;
      sclk_prev_reg <= 1'b1;
      load_prev_reg <= 1'b1;
      clock_input_a_prev_reg <= 1'b1;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
      sclk_prev_reg <= sync_reg[9];
      load_prev_reg <= sync_reg[7];
      clock_input_a_prev_reg <= sync_reg[4];
    end
  end

  // named views of the synchronised pins
  wire sclk_s = sync_reg[9];
  wire din_s = sync_reg[8];
  wire load_s = sync_reg[7];
  wire rin_s = sync_reg[6];
  wire syncclk_s = sync_reg[5];
  wire clock_input_a_s = sync_reg[4];
  wire data_s = sync_reg[3];
  wire monitor_ok_s = sync_reg[2];
  wire presence_input_s = sync_reg[1];
  wire cardclk_s = sync_reg[0];
  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire load_fall = ~load_s & load_prev_reg;
  wire clock_input_a_rise = clock_input_a_s & ~clock_input_a_prev_reg;

  logic [7:0] shift_reg;
  logic [7:0] command_reg;
  logic [7:0] status_word;
  logic elec_fault_reg;
  logic atr_fault_reg;
  logic present_reg;
  logic [DW-1:0] debounce_reg;
  logic off_reg;
  deact_state_t deact_reg;
  deact_state_t deact_next;
  logic [card_socket_pkg::TIMER_W-1:0] timer_reg;

  // command fields
  wire [1:0] cmd_supply = command_reg[card_socket_pkg::SUPPLY_LSB +: 2];
  wire cmd_select = command_reg[card_socket_pkg::SELECT_BIT];
  wire [1:0] cmd_route = command_reg[card_socket_pkg::ROUTE_LSB +: 2];
  wire [2:0] cmd_clkmode = command_reg[card_socket_pkg::CLKMODE_LSB +: 3];
  wire mode_clock_input_a = cmd_clkmode[2] | cmd_clkmode[1];
  wire mode_bidir = (cmd_clkmode == card_socket_pkg::CLK_BIDIR);
  wire powered = ~off_reg & (deact_reg == DA_IDLE);
  wire link_ok = powered & supply_ready_input;
  wire card_sel = cmd_select & link_ok;

  // live status word, low nibble reads zero
  assign status_word = {present_reg, supply_ready_input & powered, atr_fault_reg,
                        elec_fault_reg, 4'h0};

  // shift register: live status while load is low, shifts on serial rise otherwise
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 8'h00;
    end else if (!load_s) begin
      shift_reg <= status_word;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[6:0], din_s};
    end
  end
  // top bit leaves first, so the next device sees it in order
  assign serial_data_out = shift_reg[7];

  // command latch takes the word on the falling edge of load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      command_reg <= card_socket_pkg::COMMAND_RESET;
    end else if (load_fall) begin
      command_reg <= shift_reg;
    end
  end

  // sticky faults cleared by the next load; a new event wins over the clear
  wire elec_event = electrical_fault_event | (~monitor_ok_s & ~off_reg);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      elec_fault_reg <= 1'b0;
      atr_fault_reg <= 1'b0;
    end else begin
      elec_fault_reg <= elec_event | (elec_fault_reg & ~load_fall);
      atr_fault_reg <= atr_fault_event | (atr_fault_reg & ~load_fall);
    end
  end
  assign fault_out = 1'b0;
  assign fault_oe = elec_fault_reg;

  // presence debounce; a bounce restarts the wait, removal is immediate
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      debounce_reg <= '0;
      present_reg <= 1'b0;
    end else if (!presence_input_s) begin
      debounce_reg <= '0;
      present_reg <= 1'b0;
    end else if (debounce_reg == DW'(DEBOUNCE_CYCLES)) begin
      present_reg <= 1'b1;
    end else begin
      debounce_reg <= debounce_reg + DW'(1);
    end
  end

  // deactivation trigger: zero supply command, electrical fault or low monitor
  wire manual_off = load_fall & (shift_reg[card_socket_pkg::SUPPLY_LSB +: 2]
                    == card_socket_pkg::SUPPLY_OFF);
  wire start_deact = ~off_reg & (deact_reg == DA_IDLE) & (manual_off | elec_event);
  wire clock_done = (mode_clock_input_a & ~card_clock_out) |
                    (timer_reg == card_socket_pkg::TIMER_W'(card_socket_pkg::CLK_STOP_CYCLES));
  always_comb begin
    deact_next = deact_reg;
    unique case (deact_reg)
      DA_IDLE: if (start_deact) deact_next = DA_RESET;
      DA_RESET: deact_next = DA_CLOCK;
      DA_CLOCK: if (clock_done) deact_next = DA_PINS;
      DA_PINS: deact_next = DA_SUPPLY;
      DA_SUPPLY: deact_next = DA_IDLE;
      default: deact_next = DA_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      deact_reg <= DA_IDLE;
      timer_reg <= '0;
      off_reg <= 1'b1;
    end else begin
      deact_reg <= deact_next;
      timer_reg <= (deact_reg == DA_CLOCK) ? timer_reg + 1'b1 : '0;
      // power returns only by a later load that asks for a supply level
      if (deact_reg == DA_SUPPLY) begin
        off_reg <= 1'b1;
      end else if (load_fall && !manual_off && deact_reg == DA_IDLE && !elec_event) begin
        off_reg <= 1'b0;
      end
    end
  end
  wire pins_low = off_reg | (deact_reg == DA_PINS) | (deact_reg == DA_SUPPLY);
  wire clk_low = pins_low;
  wire rst_low = ~powered;

  // supply level stays until the last step of the sequence
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supply_level <= card_socket_pkg::SUPPLY_OFF;
    end else if (off_reg || deact_reg == DA_SUPPLY) begin
      supply_level <= card_socket_pkg::SUPPLY_OFF;
    end else if (deact_reg == DA_IDLE) begin
      supply_level <= cmd_supply;
    end
  end

  // card reset follows the input when selected, holds when not
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      card_reset <= 1'b0;
    end else if (rst_low) begin
      card_reset <= 1'b0;
    end else if (card_sel) begin
      card_reset <= rin_s;
    end
  end

  // clock_input_a divider; 3-bit count on source rises gives /2 /4 /8 at near 50% duty
  logic [2:0] div_reg;
  logic clock_input_a_src;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 3'h0;
    end else if (clock_input_a_rise) begin
      div_reg <= div_reg + 3'h1;
    end
  end
  always_comb begin
    unique case (cmd_clkmode[1:0])
      2'h0: clock_input_a_src = clock_input_a_s;
      2'h1: clock_input_a_src = div_reg[0];
      2'h2: clock_input_a_src = div_reg[1];
      default: clock_input_a_src = div_reg[2];
    endcase
  end

  // card clock; stop modes wait for the matching edge so no runt pulse escapes
  logic card_clk_next;
  always_comb begin
    card_clk_next = card_clock_out;
    if (clk_low) begin
      card_clk_next = 1'b0;
    end else if (deact_reg == DA_CLOCK) begin
      card_clk_next = mode_clock_input_a ? (card_clock_out & clock_input_a_src) : card_clock_out;
    end else if (cmd_clkmode == card_socket_pkg::CLK_STOP_LOW) begin
      card_clk_next = card_clock_out & clock_input_a_s;
    end else if (cmd_clkmode == card_socket_pkg::CLK_STOP_HIGH) begin
      card_clk_next = card_clock_out | clock_input_a_s;
    end else if (mode_clock_input_a) begin
      card_clk_next = clock_input_a_src;
    end else if (cmd_clkmode == card_socket_pkg::CLK_SYNC && card_sel) begin
      card_clk_next = syncclk_s;
    end else if (mode_bidir) begin
      card_clk_next = 1'b0;
    end
  end

  // bidirectional pull-downs; a side never echoes a low it drives itself
  logic drive_card_clk_reg;
  logic drive_sync_clk_reg;
  logic [1:0] card_clk_hist_reg;
  logic [1:0] sync_clk_hist_reg;
  // our own release shows on the synchronised pin two clocks late; mask it that long
  wire card_clk_busy = drive_card_clk_reg | (|card_clk_hist_reg);
  wire sync_clk_busy = drive_sync_clk_reg | (|sync_clk_hist_reg);
  wire bidir_on = mode_bidir & card_sel & ~clk_low;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      card_clock_out <= 1'b0;
      drive_card_clk_reg <= 1'b0;
      drive_sync_clk_reg <= 1'b0;
      card_clk_hist_reg <= 2'h0;
      sync_clk_hist_reg <= 2'h0;
    end else begin
      card_clock_out <= card_clk_next;
      card_clk_hist_reg <= {card_clk_hist_reg[0], drive_card_clk_reg};
      sync_clk_hist_reg <= {sync_clk_hist_reg[0], drive_sync_clk_reg};
      drive_card_clk_reg <= bidir_on & ~syncclk_s & ~sync_clk_busy;
      drive_sync_clk_reg <= bidir_on & ~cardclk_s & ~card_clk_busy;
    end
  end
  assign card_clock_oe = ~(mode_bidir & powered) | clk_low | drive_card_clk_reg;
  assign sync_clock_out = 1'b0;
  assign sync_clock_oe = drive_sync_clk_reg;

  // data path: io is open drain both ways, c4 and c8 only toward the card
  logic drive_io_reg;
  logic drive_data_reg;
  logic [1:0] io_hist_reg;
  logic [1:0] data_hist_reg;
  logic io_meta_reg;
  logic card_io_in_s;
  // same two-clock echo mask as the clock pair
  wire io_busy = drive_io_reg | (|io_hist_reg);
  wire data_busy = drive_data_reg | (|data_hist_reg);
  wire io_on = card_sel & (cmd_route == card_socket_pkg::ROUTE_IO);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      drive_io_reg <= 1'b0;
      drive_data_reg <= 1'b0;
      io_hist_reg <= 2'h0;
      data_hist_reg <= 2'h0;
      card_c4 <= 1'b0;
      card_c8 <= 1'b0;
    end else begin
      io_hist_reg <= {io_hist_reg[0], drive_io_reg};
      data_hist_reg <= {data_hist_reg[0], drive_data_reg};
      drive_io_reg <= io_on & ~data_s & ~data_busy;
      drive_data_reg <= io_on & ~card_io_in_s & ~io_busy;
      if (pins_low) begin
        card_c4 <= 1'b0;
        card_c8 <= 1'b0;
      end else begin
        if (card_sel && cmd_route == card_socket_pkg::ROUTE_C4) card_c4 <= data_s;
        if (card_sel && cmd_route == card_socket_pkg::ROUTE_C8) card_c8 <= data_s;
      end
    end
  end
  // io sampled through its own pair of flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      io_meta_reg <= 1'b1;
      card_io_in_s <= 1'b1;
    end else begin
      io_meta_reg <= card_io_in;
      card_io_in_s <= io_meta_reg;
    end
  end
  // released io idles high through the socket pull-up
  assign card_io_out = 1'b0;
  assign card_io_oe = pins_low | drive_io_reg;
  assign data_line_out = 1'b0;
  assign data_line_oe = drive_data_reg;

  // checks
  property p_shift_in;
    @(posedge clock) disable iff (!arst_n)
    (load_s && sclk_rise) |=> (shift_reg[0] == $past(din_s));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift missed data");
  property p_msb_out;
    @(posedge clock) disable iff (!arst_n)
    (load_s && sclk_rise) |=> (serial_data_out == $past(shift_reg[6]));
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("status bit order wrong");
  property p_load;
    @(posedge clock) disable iff (!arst_n)
    load_fall |=> (command_reg == $past(shift_reg));
  endproperty
  a_load: assert property (p_load) else $error("command not loaded");
  property p_live;
    @(posedge clock) disable iff (!arst_n)
    (!load_s) |=> (shift_reg == $past(status_word));
  endproperty
  a_live: assert property (p_live) else $error("status not live");
  property p_zero_nibble;
    @(posedge clock) disable iff (!arst_n) status_word[3:0] == 4'h0;
  endproperty
  a_zero_nibble: assert property (p_zero_nibble) else $error("low status bits set");
  property p_fault_pin;
    @(posedge clock) disable iff (!arst_n) fault_oe == status_word[card_socket_pkg::STAT_ELEC_FAULT];
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin mismatch");
  property p_deact_order;
    @(posedge clock) disable iff (!arst_n)
    (deact_reg == DA_RESET) |=> (card_reset == 1'b0) ##0 (deact_reg == DA_CLOCK);
  endproperty
  a_deact_order: assert property (p_deact_order) else $error("reset not low first");
  property p_clock_bound;
    @(posedge clock) disable iff (!arst_n)
    (deact_reg == DA_CLOCK) |->
      (timer_reg <= card_socket_pkg::TIMER_W'(card_socket_pkg::CLK_STOP_CYCLES));
  endproperty
  a_clock_bound: assert property (p_clock_bound) else $error("clock stop overran");
  property p_elec_deact;
    @(posedge clock) disable iff (!arst_n)
    (electrical_fault_event && deact_reg == DA_IDLE && !off_reg) |=> (deact_reg == DA_RESET);
  endproperty
  a_elec_deact: assert property (p_elec_deact) else $error("fault kept card up");
  property p_no_traffic;
    @(posedge clock) disable iff (!arst_n) !supply_ready_input |=> !drive_data_reg;
  endproperty
  a_no_traffic: assert property (p_no_traffic) else $error("traffic before ready");
  property p_present;
    @(posedge clock) disable iff (!arst_n) $rose(present_reg) |-> presence_input_s && $past(presence_input_s);
  endproperty
  a_present: assert property (p_present) else $error("presence not debounced");
  c_load: cover property (@(posedge clock) disable iff (!arst_n) load_fall);
  c_deact: cover property (@(posedge clock) disable iff (!arst_n) deact_reg == DA_SUPPLY);
  c_bidir: cover property (@(posedge clock) disable iff (!arst_n) drive_sync_clk_reg);
  c_present: cover property (@(posedge clock) disable iff (!arst_n) $rose(present_reg));
endmodule : card_socket_serial_control
`default_nettype wire

// *** verif/serial_host_model.sv ***
// host microcontroller model driving the socket's serial control link
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input wire logic clock,
  input wire logic serial_data_out,
  output logic serial_clock_in,
  output logic serial_data_in,
  output logic load_strobe,
  output logic [7:0] status_word,
  output logic status_strobe
);
  // idle: clock parked high, load high, nothing reported
  initial begin
    serial_clock_in = 1'b1;
    serial_data_in = 1'b0;
    load_strobe = 1'b1;
    status_word = 8'h00;
    status_strobe = 1'b0;
  end

  // every change lands just after a system clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk

  // one word, msb first; 13-cycle phases keep the link just under 10 MHz
  task automatic shift_word(input logic [7:0] cmd);
    logic [7:0] got;
    got = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      serial_data_in = cmd[i];
      serial_clock_in = 1'b0;
      wait_clk(13);
      got[i] = serial_data_out;
      serial_clock_in = 1'b1;
      wait_clk(13);
    end
    // released data line shows the inverse, never a stale copy
    serial_data_in = ~cmd[0];
    status_word = got;
    status_strobe = 1'b1;
    wait_clk(1);
    status_strobe = 1'b0;
  endtask : shift_word

  // load edges only while the serial clock sits high
  task automatic load_fall;
    load_strobe = 1'b0;
  endtask : load_fall

  task automatic load_rise;
    load_strobe = 1'b1;
  endtask : load_rise
endmodule : serial_host_model
`default_nettype wire

// *** verif/tb.sv ***
// self-checking testbench for the socket serial control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock, arst_n, reset_input, clock_input_a, supply_monitor_input, presence_input;
  logic electrical_fault_event, atr_fault_event, supply_ready_input;
  logic sync_drv, card_pull, data_drv, io_drv;
  logic serial_clock_in, serial_data_in, load_strobe, serial_data_out, status_strobe;
  logic sync_clock_out, sync_clock_oe, data_line_out, data_line_oe, fault_out, fault_oe;
  logic card_reset, card_clock_out, card_clock_oe, card_io_out, card_io_oe, card_c4, card_c8;
  logic [1:0] supply_level, sup;
  logic [7:0] status_word, stat_exp, per;
  logic present_v, powered_v, atr_v, elec_v, bit_v;
  logic [7:0] notes[$];
  int fail_count, n_compared, cycles, seed;
  // wire levels from every party's enable; pull-ups idle high
  wire sync_clock_in = (sync_clock_oe ? sync_clock_out : 1'b1) & sync_drv;
  wire card_clock_in = (card_clock_oe ? card_clock_out : 1'b1) & ~card_pull;
  wire data_line_in = (data_line_oe ? data_line_out : 1'b1) & data_drv;
  wire card_io_in = (card_io_oe ? card_io_out : 1'b1) & io_drv;

  card_socket_serial_control #(.DEBOUNCE_CYCLES(50)) i_card_socket_serial_control (
    .clock(clock), .arst_n(arst_n), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in), .load_strobe(load_strobe),
    .serial_data_out(serial_data_out), .reset_input(reset_input),
    .sync_clock_in(sync_clock_in), .sync_clock_out(sync_clock_out),
    .sync_clock_oe(sync_clock_oe), .clock_input_a(clock_input_a),
    .data_line_in(data_line_in), .data_line_out(data_line_out), .data_line_oe(data_line_oe),
    .supply_monitor_input(supply_monitor_input), .presence_input(presence_input),
    .electrical_fault_event(electrical_fault_event), .atr_fault_event(atr_fault_event),
    .supply_ready_input(supply_ready_input), .fault_out(fault_out), .fault_oe(fault_oe),
    .supply_level(supply_level), .card_reset(card_reset), .card_clock_in(card_clock_in),
    .card_clock_out(card_clock_out), .card_clock_oe(card_clock_oe), .card_io_in(card_io_in),
    .card_io_out(card_io_out), .card_io_oe(card_io_oe), .card_c4(card_c4), .card_c8(card_c8)
  );

  serial_host_model host (
    .clock(clock), .serial_data_out(serial_data_out), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in), .load_strobe(load_strobe), .status_word(status_word),
    .status_strobe(status_strobe)
  );

  // 4 ns system clock; clock_input_a card clock of 64 ns, phase unrelated
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    clock_input_a = 1'b0;
    #5;
    forever #32 clock_input_a = ~clock_input_a;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // pin level compare and status word compare
  task automatic cmp_pin(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic cmp_status(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: status got %h expected %h", $time, got, exp);
    end
  endtask : cmp_status

  // the word read now is the one frozen at the previous load rise
  task automatic xfer(input logic [7:0] cmd);
    notes.push_back(stat_exp);
    host.shift_word(cmd);
    host.load_fall();
    step(8);
    powered_v = (|cmd[1:0]) & ~elec_v;
    host.load_rise();
    stat_exp = {present_v, powered_v, atr_v, elec_v, 4'h0};
    step(8);
  endtask : xfer

  // measures system cycles between two card clock rises
  task automatic measure(output logic [7:0] n);
    logic p;
    int c;
    int s;
    c = 0;
    s = 0;
    n = 8'h00;
    p = card_clock_out;
    while (s < 2 && c < 600) begin
      step(1);
      c++;
      if (s == 1) n++;
      if (p === 1'b0 && card_clock_out === 1'b1) s++;
      p = card_clock_out;
    end
  endtask : measure

  // status results come off the queue in order
  always @(posedge clock) begin
    if (status_strobe === 1'b1) cmp_status(status_word, notes.pop_front());
  end

  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    {arst_n, reset_input, presence_input, electrical_fault_event, atr_fault_event} = 5'h00;
    {supply_monitor_input, supply_ready_input, sync_drv, data_drv, io_drv} = 5'h1f;
    {card_pull, present_v, powered_v, atr_v, elec_v} = 5'h00;
    {fail_count, n_compared, cycles} = 0;
    stat_exp = 8'h00;
    seed = 32'hf66a;
    step(6);
    arst_n = 1'b1;
    step(4);
    cmp_pin(supply_level === 2'h0, 1'b1);
    xfer(8'h00);
    // live presence while load is low, with debounce
    host.load_fall();
    presence_input = 1'b1;
    step(30);
    cmp_pin(serial_data_out, 1'b0);
    step(50);
    cmp_pin(serial_data_out, 1'b1);
    presence_input = 1'b0;
    step(8);
    cmp_pin(serial_data_out, 1'b0);
    presence_input = 1'b1;
    step(80);
    present_v = 1'b1;
    host.load_rise();
    stat_exp = 8'h80;
    step(8);
    // power up, selected, io routed, sync clock
    sup = 2'($random(seed));
    if (sup == 2'h0) sup = 2'h3;
    xfer({card_socket_pkg::CLK_SYNC, card_socket_pkg::ROUTE_IO, 1'b1, sup});
    cmp_pin(supply_level === sup, 1'b1);
    reset_input = 1'b1;
    sync_drv = 1'b0;
    bit_v = 1'($random(seed));
    data_drv = bit_v;
    step(8);
    cmp_pin(card_reset, 1'b1);
    cmp_pin(card_clock_out, 1'b0);
    cmp_pin(card_io_oe, ~bit_v);
    {sync_drv, data_drv, io_drv} = 3'h6;
    step(8);
    cmp_pin(card_clock_out, 1'b1);
    cmp_pin(data_line_oe, 1'b1);
    // no relay while the card supply is not ready
    supply_ready_input = 1'b0;
    step(8);
    cmp_pin(data_line_oe | card_io_oe, 1'b0);
    {io_drv, supply_ready_input} = 2'h3;
    // deselect: reset and clock hold, io idles high
    xfer({card_socket_pkg::CLK_SYNC, card_socket_pkg::ROUTE_IO, 1'b0, sup});
    {reset_input, sync_drv, data_drv} = 3'h0;
    step(8);
    cmp_pin(card_reset, 1'b1);
    cmp_pin(card_clock_out, 1'b1);
    cmp_pin(card_io_oe | data_line_oe, 1'b0);
    {sync_drv, data_drv} = 2'h3;
    // c4 then c8 follow the data line; c4 holds after
    for (int k = 1; k <= 2; k++) begin
      xfer({card_socket_pkg::CLK_SYNC, 2'(k), 1'b1, sup});
      repeat (3) begin
        bit_v = 1'($random(seed));
        data_drv = bit_v;
        step(6);
        cmp_pin((k == 1) ? card_c4 : card_c8, bit_v);
        if (k == 1) per[0] = bit_v;
      end
    end
    cmp_pin(card_c4, per[0]);
    data_drv = 1'b1;
    // asynchronous stop and divide modes
    for (int m = 2; m <= 7; m++) begin
      xfer({3'(m), card_socket_pkg::ROUTE_NONE, 1'b1, sup});
      step(1100);
      if (m < 4) begin
        cmp_pin(card_clock_out, 1'(m));
      end else begin
        measure(per);
        cmp_status(per, 8'(16 << (m - 4)));
      end
    end
    // bidirectional clock: either side pulls the shared line low
    xfer({card_socket_pkg::CLK_BIDIR, card_socket_pkg::ROUTE_NONE, 1'b1, sup});
    step(300);
    card_pull = 1'b1;
    step(8);
    cmp_pin(sync_clock_oe, 1'b1);
    card_pull = 1'b0;
    sync_drv = 1'b0;
    step(8);
    cmp_pin(card_clock_oe & ~sync_clock_oe, 1'b1);
    sync_drv = 1'b1;
    step(300);
    // answer-to-reset fault is reported only
    atr_fault_event = 1'b1;
    atr_v = 1'b1;
    xfer({card_socket_pkg::CLK_SYNC, card_socket_pkg::ROUTE_IO, 1'b1, sup});
    atr_fault_event = 1'b0;
    atr_v = 1'b0;
    reset_input = 1'b1;
    step(8);
    cmp_pin(supply_level === sup && fault_oe === 1'b0, 1'b1);
    // electrical fault: reset drops first, supply goes last
    electrical_fault_event = 1'b1;
    step(1);
    electrical_fault_event = 1'b0;
    step(5);
    cmp_pin(fault_oe === 1'b1 && card_reset === 1'b0, 1'b1);
    cmp_pin(supply_level === sup, 1'b1);
    step(1500);
    cmp_pin(supply_level === 2'h0 && card_io_oe === 1'b1, 1'b1);
    electrical_fault_event = 1'b1;
    elec_v = 1'b1;
    xfer(8'h00);
    electrical_fault_event = 1'b0;
    elec_v = 1'b0;
    xfer(8'h00);
    cmp_pin(fault_oe, 1'b0);
    // supply monitor below threshold deactivates
    xfer({card_socket_pkg::CLK_SYNC, card_socket_pkg::ROUTE_IO, 1'b1, sup});
    supply_monitor_input = 1'b0;
    step(20);
    supply_monitor_input = 1'b1;
    step(1500);
    cmp_pin(supply_level === 2'h0 && fault_oe === 1'b1, 1'b1);
    xfer(8'h00);
    close_out();
  end
endmodule : tb
`default_nettype wire
